/* File: msd_pkg.sv */
package msd_pkg;

    // Register addresses on the serial port
    localparam logic [6:0] MSD_ADDR_VERSION  = 7'h01;
    localparam logic [6:0] MSD_ADDR_STATUS   = 7'h02;
    localparam logic [6:0] MSD_ADDR_X_LOW    = 7'h03;
    localparam logic [6:0] MSD_ADDR_X_HIGH   = 7'h04;
    localparam logic [6:0] MSD_ADDR_Y_LOW    = 7'h05;
    localparam logic [6:0] MSD_ADDR_Y_HIGH   = 7'h06;

    // Status byte field positions
    localparam int MSD_ST_MOVEMENT  = 7;
    localparam int MSD_ST_LASER_SHT = 6;
    localparam int MSD_ST_POWER_OK  = 5;
    localparam int MSD_ST_STATE_HI  = 2;
    localparam int MSD_ST_STATE_LO  = 1;
    localparam int MSD_ST_ORIGIN    = 0;

    // Serial command byte: top bit selects a write
    localparam int MSD_CMD_WRITE_BIT = 7;

    // Reset values and last bit count
    localparam logic [7:0]  MSD_STATUS_RST = 8'h00;
    localparam logic [15:0] MSD_MOVE_RST   = 16'h0000;
    localparam logic [7:0]  MSD_BYTE_RST   = 8'h00;
    localparam logic [2:0]  MSD_BITCNT_RST = 3'h0;
    localparam logic [2:0]  MSD_BITCNT_LST = 3'h7;

    // Revision code; value is arbitrary
    localparam logic [7:0]  MSD_SILICON_VERSION = 8'hA5;

    // Operating modes as reported in the status byte
    localparam logic [1:0] MSD_MODE_RUN   = 2'h0;
    localparam logic [1:0] MSD_MODE_REST1 = 2'h1;
    localparam logic [1:0] MSD_MODE_REST2 = 2'h2;
    localparam logic [1:0] MSD_MODE_REST3 = 2'h3;

endpackage

/* File: msd_spi_port.sv */
`timescale 1ns/1ns
module msd_spi_port
    import msd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       ncs_b,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic [7:0] rd_data,
    output logic            miso_out,
    output logic            miso_oe,
    output logic            rd_stb,
    output logic            wr_stb,
    output logic [6:0]      reg_addr,
    output logic [7:0]      wr_data
);

    logic       ncs_s1_reg, ncs_s2_reg;
    logic       sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
    logic       mosi_s1_reg, mosi_s2_reg;
    logic [2:0] bit_cnt_reg;
    logic       data_phase_reg;
    logic [7:0] shift_in_reg;
    logic [7:0] cmd_reg;
    logic [7:0] shift_out_reg;
    logic       load_reg;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] byte_done;

    // Two-stage synchronisers for the port pins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ncs_s1_reg  <= 1'b1;
            ncs_s2_reg  <= 1'b1;
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_d_reg  <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end else begin
            ncs_s1_reg  <= ncs_b;
            ncs_s2_reg  <= ncs_s1_reg;
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_d_reg  <= sclk_s2_reg;
            mosi_s1_reg <= mosi;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    assign sclk_rise = sclk_s2_reg & ~sclk_d_reg & ~ncs_s2_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_d_reg & ~ncs_s2_reg;
    assign byte_done = {shift_in_reg[6:0], mosi_s2_reg};

    // Command byte then data byte, MSB first, sampled on SCLK rise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_reg    <= MSD_BITCNT_RST;
            data_phase_reg <= 1'b0;
            shift_in_reg   <= MSD_BYTE_RST;
            cmd_reg        <= MSD_BYTE_RST;
            wr_data        <= MSD_BYTE_RST;
            rd_stb         <= 1'b0;
            wr_stb         <= 1'b0;
        end else begin
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            if (ncs_s2_reg) begin
                bit_cnt_reg    <= MSD_BITCNT_RST;
                data_phase_reg <= 1'b0;
            end else if (sclk_rise) begin
                shift_in_reg <= byte_done;
                bit_cnt_reg  <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == MSD_BITCNT_LST) begin
                    if (!data_phase_reg) begin
                        cmd_reg        <= byte_done;
                        data_phase_reg <= 1'b1;
                        rd_stb         <= ~byte_done[MSD_CMD_WRITE_BIT];
                    end else begin
                        data_phase_reg <= 1'b0;
                        wr_data        <= byte_done;
                        wr_stb         <= cmd_reg[MSD_CMD_WRITE_BIT];
                    end
                end
            end
        end
    end

    assign reg_addr = cmd_reg[6:0];

    // Reply byte shifts out on SCLK fall
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            load_reg      <= 1'b0;
            shift_out_reg <= MSD_BYTE_RST;
            miso_out      <= 1'b0;
            miso_oe       <= 1'b0;
        end else begin
            load_reg <= rd_stb;
            miso_oe  <= ~ncs_s2_reg;
            if (load_reg) begin
                shift_out_reg <= rd_data;
            end else if (sclk_fall) begin
                miso_out      <= shift_out_reg[7];
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
        end
    end

    property p_port_idle;
        @(posedge mclk) disable iff (!rst_b)
        ncs_s2_reg |=> !miso_oe && !rd_stb && !wr_stb;
    endproperty
    a_port_idle: assert property (p_port_idle) else $error("port active while deselected");

endmodule

/* File: msd_motion_readout.sv */
`timescale 1ns/1ns
// How it works
// - Movement flag set while motion is pending
// - Status read freezes displacement snapshot
// - Second status read overwrites unread snapshot
// - Status write clears flag and snapshot
// - Bit 6 shows laser drive shorted
// - Bit 5 shows power settings complementary
// - Bits 2:1 show current power state
// - Bit 0 marks capture from pixel origin
// - X is 16-bit two's complement, low/high
// - Y is 16-bit two's complement, low/high
// - Each displacement byte clears when read
// - Read-only silicon version byte
// - All access through four-wire serial port
module msd_motion_readout
    import msd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        ncs_b,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso_out,
    output logic             miso_oe,
    input  wire logic        move_valid,
    input  wire logic [15:0] move_x,
    input  wire logic [15:0] move_y,
    input  wire logic        laser_drive_output_short,
    input  wire logic [7:0]  laser_power_set,
    input  wire logic [7:0]  laser_power_set_inv,
    input  wire logic [1:0]  power_state_in,
    input  wire logic        capture_origin_in
);

    logic        rd_stb;
    logic        wr_stb;
    logic [6:0]  reg_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data_reg;

    logic [15:0] acc_x_reg, acc_y_reg;
    logic [15:0] snap_x_reg, snap_y_reg;
    logic        movement_seen_reg;
    logic        short_s1_reg, short_s2_reg;
    logic        laser_short_flag_reg;
    logic        laser_power_ok_reg;
    logic [1:0]  power_state_reg;
    logic        capture_origin_flag_reg;
    logic [7:0]  status_byte;
    logic        status_rd, status_wr;
    logic        new_motion;
    logic [15:0] in_x, in_y;

    // Four-wire serial port; all register traffic arrives here
    msd_spi_port u_port (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ncs_b    (ncs_b),
        .sclk     (sclk),
        .mosi     (mosi),
        .rd_data  (rd_data_reg),
        .miso_out (miso_out),
        .miso_oe  (miso_oe),
        .rd_stb   (rd_stb),
        .wr_stb   (wr_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data)
    );

    assign status_rd  = rd_stb && (reg_addr == MSD_ADDR_STATUS);
    assign status_wr  = wr_stb && (reg_addr == MSD_ADDR_STATUS);
    assign new_motion = move_valid && ((move_x != MSD_MOVE_RST) || (move_y != MSD_MOVE_RST));
    assign in_x       = move_valid ? move_x : MSD_MOVE_RST;
    assign in_y       = move_valid ? move_y : MSD_MOVE_RST;

    // Running totals; motion of the draining cycle seeds the next total
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_x_reg <= MSD_MOVE_RST;
            acc_y_reg <= MSD_MOVE_RST;
        end else if (status_rd || status_wr) begin
            acc_x_reg <= in_x;
            acc_y_reg <= in_y;
        end else begin
            acc_x_reg <= acc_x_reg + in_x;
            acc_y_reg <= acc_y_reg + in_y;
        end
    end

    // Snapshot seen by the four displacement byte registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            snap_x_reg <= MSD_MOVE_RST;
            snap_y_reg <= MSD_MOVE_RST;
        end else if (status_wr) begin
            snap_x_reg <= MSD_MOVE_RST;
            snap_y_reg <= MSD_MOVE_RST;
        end else if (status_rd) begin
            snap_x_reg <= acc_x_reg;
            snap_y_reg <= acc_y_reg;
        end else if (rd_stb) begin
            unique case (reg_addr)
                MSD_ADDR_X_LOW:  snap_x_reg[7:0]  <= MSD_BYTE_RST;
                MSD_ADDR_X_HIGH: snap_x_reg[15:8] <= MSD_BYTE_RST;
                MSD_ADDR_Y_LOW:  snap_y_reg[7:0]  <= MSD_BYTE_RST;
                MSD_ADDR_Y_HIGH: snap_y_reg[15:8] <= MSD_BYTE_RST;
                default: begin
                end
            endcase
        end
    end

    // Movement flag; fresh motion wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            movement_seen_reg <= 1'b0;
        end else if (new_motion) begin
            movement_seen_reg <= 1'b1;
        end else if (status_rd || status_wr) begin
            movement_seen_reg <= 1'b0;
        end
    end

    // Laser short detector is asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            short_s1_reg         <= 1'b0;
            short_s2_reg         <= 1'b0;
            laser_short_flag_reg <= 1'b0;
        end else begin
            short_s1_reg         <= laser_drive_output_short;
            short_s2_reg         <= short_s1_reg;
            laser_short_flag_reg <= short_s2_reg;
        end
    end

    // Laser power check and frame state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            laser_power_ok_reg      <= 1'b0;
            power_state_reg         <= MSD_MODE_RUN;
            capture_origin_flag_reg <= 1'b0;
        end else begin
            laser_power_ok_reg      <= (laser_power_set == ~laser_power_set_inv);
            power_state_reg         <= power_state_in;
            capture_origin_flag_reg <= capture_origin_in;
        end
    end

    always_comb begin
        status_byte                   = MSD_STATUS_RST;
        status_byte[MSD_ST_MOVEMENT]  = movement_seen_reg;
        status_byte[MSD_ST_LASER_SHT] = laser_short_flag_reg;
        status_byte[MSD_ST_POWER_OK]  = laser_power_ok_reg;
        status_byte[MSD_ST_STATE_HI:MSD_ST_STATE_LO] = power_state_reg;
        status_byte[MSD_ST_ORIGIN]    = capture_origin_flag_reg;
    end

    // Read reply captured before any read side effect lands
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg <= MSD_BYTE_RST;
        end else if (rd_stb) begin
            unique case (reg_addr)
                MSD_ADDR_VERSION: rd_data_reg <= MSD_SILICON_VERSION;
                MSD_ADDR_STATUS:  rd_data_reg <= status_byte;
                MSD_ADDR_X_LOW:   rd_data_reg <= snap_x_reg[7:0];
                MSD_ADDR_X_HIGH:  rd_data_reg <= snap_x_reg[15:8];
                MSD_ADDR_Y_LOW:   rd_data_reg <= snap_y_reg[7:0];
                MSD_ADDR_Y_HIGH:  rd_data_reg <= snap_y_reg[15:8];
                default:          rd_data_reg <= MSD_BYTE_RST;
            endcase
        end
    end

    // Written byte is only a trigger and is never stored
    logic unused_wr;
    assign unused_wr = ^wr_data;

    property p_mot_set;
        @(posedge mclk) disable iff (!rst_b)
        new_motion |=> movement_seen_reg;
    endproperty
    a_mot_set: assert property (p_mot_set) else $error("movement flag not set");

    property p_mot_clear;
        @(posedge mclk) disable iff (!rst_b)
        (status_rd || status_wr) && !new_motion |=> !movement_seen_reg;
    endproperty
    a_mot_clear: assert property (p_mot_clear) else $error("movement flag not cleared");

    property p_snapshot;
        @(posedge mclk) disable iff (!rst_b)
        status_rd && !status_wr |=> snap_x_reg == $past(acc_x_reg) && snap_y_reg == $past(acc_y_reg);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

    property p_snap_stable;
        @(posedge mclk) disable iff (!rst_b)
        !rd_stb && !wr_stb |=> $stable(snap_x_reg) && $stable(snap_y_reg);
    endproperty
    a_snap_stable: assert property (p_snap_stable) else $error("snapshot moved");

    sequence s_unread_snap;
        status_rd && (snap_x_reg != MSD_MOVE_RST || snap_y_reg != MSD_MOVE_RST);
    endsequence
    property p_reread;
        @(posedge mclk) disable iff (!rst_b)
        s_unread_snap |=> snap_x_reg == $past(acc_x_reg) && snap_y_reg == $past(acc_y_reg);
    endproperty
    a_reread: assert property (p_reread) else $error("old snapshot kept");

    property p_wr_clear;
        @(posedge mclk) disable iff (!rst_b)
        status_wr |=> snap_x_reg == MSD_MOVE_RST && snap_y_reg == MSD_MOVE_RST;
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write did not clear");

    sequence s_short_held;
        laser_drive_output_short [*4];
    endsequence
    property p_short;
        @(posedge mclk) disable iff (!rst_b)
        s_short_held |-> laser_short_flag_reg;
    endproperty
    a_short: assert property (p_short) else $error("laser short not reported");

    property p_power_ok;
        @(posedge mclk) disable iff (!rst_b)
        (laser_power_set != ~laser_power_set_inv) |=> !laser_power_ok_reg;
    endproperty
    a_power_ok: assert property (p_power_ok) else $error("bad laser power reported ok");

    property p_state;
        @(posedge mclk) disable iff (!rst_b)
        ##1 status_byte[2:1] == $past(power_state_in) && status_byte[0] == $past(capture_origin_in);
    endproperty
    a_state: assert property (p_state) else $error("frame state not reported");

    property p_accumulate;
        @(posedge mclk) disable iff (!rst_b)
        move_valid && !status_rd && !status_wr |=> acc_x_reg == 16'($past(acc_x_reg) + $past(move_x));
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("motion lost");

    property p_read_clear;
        @(posedge mclk) disable iff (!rst_b)
        rd_stb && reg_addr == MSD_ADDR_Y_HIGH |=> snap_y_reg[15:8] == MSD_BYTE_RST;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("byte not cleared on read");

    property p_version;
        @(posedge mclk) disable iff (!rst_b)
        rd_stb && reg_addr == MSD_ADDR_VERSION |=> rd_data_reg == MSD_SILICON_VERSION;
    endproperty
    a_version: assert property (p_version) else $error("wrong version byte");

    property p_read_clear_x;
        @(posedge mclk) disable iff (!rst_b)
        rd_stb && reg_addr == MSD_ADDR_X_LOW |=> snap_x_reg[7:0] == MSD_BYTE_RST;
    endproperty
    a_read_clear_x: assert property (p_read_clear_x) else $error("low byte not cleared on read");

    property p_status_reply;
        @(posedge mclk) disable iff (!rst_b)
        rd_stb && reg_addr == MSD_ADDR_STATUS |=> rd_data_reg == $past(status_byte);
    endproperty
    a_status_reply: assert property (p_status_reply) else $error("status reply wrong");

    property p_acc_restart;
        @(posedge mclk) disable iff (!rst_b)
        status_rd || status_wr |=> acc_x_reg == $past(in_x) && acc_y_reg == $past(in_y);
    endproperty
    a_acc_restart: assert property (p_acc_restart) else $error("draining motion lost");

    property p_accumulate_y;
        @(posedge mclk) disable iff (!rst_b)
        move_valid && !status_rd && !status_wr |=> acc_y_reg == 16'($past(acc_y_reg) + $past(move_y));
    endproperty
    a_accumulate_y: assert property (p_accumulate_y) else $error("y motion lost");

    property p_power_good;
        @(posedge mclk) disable iff (!rst_b)
        (laser_power_set == ~laser_power_set_inv) |=> laser_power_ok_reg;
    endproperty
    a_power_good: assert property (p_power_good) else $error("good laser power reported bad");

    sequence s_short_off;
        !laser_drive_output_short [*4];
    endsequence
    property p_short_gone;
        @(posedge mclk) disable iff (!rst_b)
        s_short_off |-> !laser_short_flag_reg;
    endproperty
    a_short_gone: assert property (p_short_gone) else $error("laser short reported without fault");

endmodule

/* File: msd_host_model.sv */
`timescale 1ns/1ns
module msd_host_model
    import msd_pkg::*;
(
    input  wire logic mclk,
    output logic      ncs_b,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso_out,
    input  wire logic miso_oe
);
    localparam int HALF = 8;
    localparam int GAP  = 16;

    // Reply is only valid while the device drives the line
    wire logic miso_line = miso_oe ? miso_out : 1'bz;

    initial begin
        ncs_b = 1'b1;
        sclk  = 1'b1;
        mosi  = 1'b0;
    end

    // Data set on the fall, taken on the rise, MSB first
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b0;
            mosi <= tx[i];
            repeat (HALF) @(posedge mclk);
            sclk  <= 1'b1;
            rx[i] = miso_line;
        end
    endtask

    task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rx);
        logic [7:0] unused;
        @(posedge mclk);
        ncs_b <= 1'b0;
        shift(cmd, unused);
        repeat (GAP) @(posedge mclk);
        shift(wd, rx);
        repeat (HALF) @(posedge mclk);
        ncs_b <= 1'b1;
        mosi  <= ~mosi;
        repeat (GAP) @(posedge mclk);
    endtask

    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        frame({1'b0, addr}, 8'hFF, data);
    endtask

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        frame({1'b1, addr}, data, unused);
    endtask

    // Status first, then each axis low byte before high byte
    task automatic read_motion(output logic [7:0] st, output logic [15:0] x, output logic [15:0] y);
        read_reg(MSD_ADDR_STATUS, st);
        read_reg(MSD_ADDR_X_LOW, x[7:0]);
        read_reg(MSD_ADDR_X_HIGH, x[15:8]);
        read_reg(MSD_ADDR_Y_LOW, y[7:0]);
        read_reg(MSD_ADDR_Y_HIGH, y[15:8]);
    endtask
endmodule

/* File: tb_motion_status_delta_readout.sv */
`timescale 1ns/1ns
module tb_motion_status_delta_readout
    import msd_pkg::*;
;
    typedef struct {
        logic       short_in;
        logic [7:0] pwr_set;
        logic [7:0] pwr_inv;
        logic [1:0] state;
        logic       origin;
        logic [7:0] status;
    } msd_row_s;

    logic        mclk;
    logic        rst_b;
    logic        ncs_b;
    logic        sclk;
    logic        mosi;
    logic        miso_out;
    logic        miso_oe;
    logic        move_valid;
    logic [15:0] move_x;
    logic [15:0] move_y;
    logic        short_in;
    logic [7:0]  pwr_set;
    logic [7:0]  pwr_inv;
    logic [1:0]  state;
    logic        origin;
    int          n_errors;
    int          n_compared;
    logic [7:0]  st;
    logic [15:0] x;
    logic [15:0] y;
    msd_row_s    rows [5] = '{
        '{1'b0, 8'h00, 8'hFF, MSD_MODE_RUN,   1'b0, 8'h20},
        '{1'b1, 8'h3C, 8'hC3, MSD_MODE_REST1, 1'b1, 8'h63},
        '{1'b0, 8'h12, 8'h12, MSD_MODE_REST2, 1'b0, 8'h04},
        '{1'b1, 8'h80, 8'h7F, MSD_MODE_REST3, 1'b0, 8'h66},
        '{1'b0, 8'h55, 8'hAB, MSD_MODE_RUN,   1'b1, 8'h01}};

    msd_motion_readout DUT (
        .mclk                     (mclk),
        .rst_b                    (rst_b),
        .ncs_b                    (ncs_b),
        .sclk                     (sclk),
        .mosi                     (mosi),
        .miso_out                 (miso_out),
        .miso_oe                  (miso_oe),
        .move_valid               (move_valid),
        .move_x                   (move_x),
        .move_y                   (move_y),
        .laser_drive_output_short (short_in),
        .laser_power_set          (pwr_set),
        .laser_power_set_inv      (pwr_inv),
        .power_state_in           (state),
        .capture_origin_in        (origin)
    );

    msd_host_model u_host (
        .mclk     (mclk),
        .ncs_b    (ncs_b),
        .sclk     (sclk),
        .mosi     (mosi),
        .miso_out (miso_out),
        .miso_oe  (miso_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.read_reg(a, d);
        check(d, e);
    endtask

    task automatic chk_motion(input logic [7:0] est, input logic [15:0] ex, input logic [15:0] ey);
        u_host.read_motion(st, x, y);
        check(st, est);
        check(x[7:0], ex[7:0]);
        check(x[15:8], ex[15:8]);
        check(y[7:0], ey[7:0]);
        check(y[15:8], ey[15:8]);
    endtask

    task automatic move(input logic [15:0] dx, input logic [15:0] dy);
        @(posedge mclk);
        move_valid <= 1'b1;
        move_x     <= dx;
        move_y     <= dy;
        @(posedge mclk);
        move_valid <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask

    initial begin
        rst_b      = 1'b0;
        move_valid = 1'b0;
        move_x     = 16'h0000;
        move_y     = 16'h0000;
        short_in   = 1'b0;
        pwr_set    = 8'h00;
        pwr_inv    = 8'hFF;
        state      = MSD_MODE_RUN;
        origin     = 1'b0;
        n_errors   = 0;
        n_compared = 0;
        fork
            run_scenarios();
            begin
                repeat (60000) @(posedge mclk);
                n_errors++;
            end
        join_any
        conclude();
    end

    task automatic run_scenarios();
        do_reset();
        check({6'h00, miso_oe, miso_out}, 8'h00);
        foreach (rows[i]) begin
            @(posedge mclk);
            short_in <= rows[i].short_in;
            pwr_set  <= rows[i].pwr_set;
            pwr_inv  <= rows[i].pwr_inv;
            state    <= rows[i].state;
            origin   <= rows[i].origin;
            rd_chk(MSD_ADDR_STATUS, rows[i].status);
        end
        @(posedge mclk);
        short_in <= 1'b0;
        pwr_set  <= 8'h00;
        pwr_inv  <= 8'hFF;
        state    <= MSD_MODE_RUN;
        origin   <= 1'b0;
        move(16'h1234, 16'hFFFD);
        move(16'h0010, 16'h0001);
        chk_motion(8'hA0, 16'h1244, 16'hFFFE);
        // Snapshot held while new motion arrives; bytes clear one by one
        move(16'h0102, 16'h8000);
        rd_chk(MSD_ADDR_STATUS, 8'hA0);
        move(16'h0005, 16'h0007);
        rd_chk(MSD_ADDR_X_LOW, 8'h02);
        rd_chk(MSD_ADDR_X_LOW, 8'h00);
        rd_chk(MSD_ADDR_X_HIGH, 8'h01);
        rd_chk(MSD_ADDR_X_HIGH, 8'h00);
        rd_chk(MSD_ADDR_Y_LOW, 8'h00);
        rd_chk(MSD_ADDR_Y_HIGH, 8'h80);
        rd_chk(MSD_ADDR_Y_HIGH, 8'h00);
        chk_motion(8'hA0, 16'h0005, 16'h0007);
        // Unread snapshot replaced by a second status read
        move(16'h0011, 16'h0022);
        rd_chk(MSD_ADDR_STATUS, 8'hA0);
        move(16'h0033, 16'h0044);
        chk_motion(8'hA0, 16'h0033, 16'h0044);
        chk_motion(8'h20, 16'h0000, 16'h0000);
        // Status write wipes flag, snapshot and pending totals
        move(16'h0055, 16'h0066);
        rd_chk(MSD_ADDR_STATUS, 8'hA0);
        move(16'h0077, 16'h0088);
        u_host.write_reg(MSD_ADDR_STATUS, 8'hFF);
        rd_chk(MSD_ADDR_X_LOW, 8'h00);
        chk_motion(8'h20, 16'h0000, 16'h0000);
        move(16'h0099, 16'h00AA);
        do_reset();
        check({6'h00, miso_oe, miso_out}, 8'h00);
        chk_motion(8'h20, 16'h0000, 16'h0000);
        rd_chk(MSD_ADDR_VERSION, MSD_SILICON_VERSION);
        u_host.write_reg(MSD_ADDR_VERSION, 8'h5A);
        rd_chk(MSD_ADDR_VERSION, MSD_SILICON_VERSION);
        rd_chk(7'h07, 8'h00);
    endtask
endmodule
